// ### sit_ctl.sv
`timescale 1ns/100ps
`default_nettype none
module sit_ctl #(
  parameter int HALF_NS = 410
) (
  input  wire logic scl,
  input  wire logic sda,
  output logic      scl_low,
  output logic      sda_low,
  output logic      hang
);
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
    hang    = 1'b0;
  end

  // Releases the clock and waits while the target stretches it.
  task automatic rise();
    int n;
    #(HALF_NS);
    scl_low = 1'b0;
    for (n = 0; n < 4000 && scl !== 1'b1; n++) #25;
    if (scl !== 1'b1) hang = 1'b1;
    #(HALF_NS);
  endtask

  task automatic clk_bit(input logic b, output logic r);
    sda_low = !b;
    rise();
    r = sda;
    scl_low = 1'b1;
  endtask

  task automatic start();
    sda_low = 1'b0;
    rise();
    sda_low = 1'b1;
    #(HALF_NS);
    scl_low = 1'b1;
  endtask

  task automatic stop();
    sda_low = 1'b1;
    rise();
    sda_low = 1'b0;
    #(HALF_NS);
  endtask

  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) clk_bit(d[i], r);
    clk_bit(1'b1, r);
    ack = !r;
  endtask

  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, r);
      d[i] = r;
    end
    clk_bit(last, r);
  endtask
endmodule
`default_nettype wire

// ### sit_i2c_target.sv
`timescale 1ns/100ps
`default_nettype none
`include "sit_params.svh"

module sit_i2c_target #(
  parameter int ADDR_LOAD_CYCLES = `SIT_ADDR_LOAD_CYC,
  parameter int BUS_IDLE_CYCLES  = `SIT_BUS_IDLE_CYC
) (
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic              scl_link,
  input  wire logic              scl_i,
  output logic                   scl_o,
  output logic                   scl_oe,
  input  wire logic              sda_i,
  output logic                   sda_o,
  output logic                   sda_oe,
  input  wire logic              addr_select_upper_pin,
  input  wire logic              addr_select_lower_pin,
  input  wire logic [7:0]        stored_address_byte,
  output sit_pkg::sit_acc_t      acc,
  output logic                   acc_valid,
  input  wire logic              acc_ready,
  input  wire logic [7:0]        acc_rdata,
  output logic [6:0]             target_bus_address,
  output logic                   addr_valid,
  output logic                   nvm_read_mode,
  output logic                   bus_busy
);

  // ========================================================================
  // Link domain: the receive shifter runs on the bus clock itself.
  logic [7:0] rx_shift;

  always_ff @(posedge scl_link or negedge rstn) begin
    if (!rstn) begin
      rx_shift <= 8'h00;
    end else begin
      rx_shift <= {rx_shift[6:0], sda_i};
    end
  end

  // ========================================================================
  // Pin synchronisers.
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic [1:0] pin_hi_sync;
  logic [1:0] pin_lo_sync;
  logic       scl_q;
  logic       sda_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      scl_sync    <= 2'h3;
      sda_sync    <= 2'h3;
      pin_hi_sync <= 2'h0;
      pin_lo_sync <= 2'h0;
      scl_q       <= 1'b1;
      sda_q       <= 1'b1;
    end else begin
      scl_sync    <= {scl_sync[0], scl_i};
      sda_sync    <= {sda_sync[0], sda_i};
      pin_hi_sync <= {pin_hi_sync[0], addr_select_upper_pin};
      pin_lo_sync <= {pin_lo_sync[0], addr_select_lower_pin};
      scl_q       <= scl_sync[1];
      sda_q       <= sda_sync[1];
    end
  end

  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  assign scl_s     = scl_sync[1];
  assign sda_s     = sda_sync[1];
  assign scl_rise  = scl_s & ~scl_q;
  assign scl_fall  = ~scl_s & scl_q;
  assign start_det = scl_s & scl_q & sda_q & ~sda_s;  // [RL2]
  assign stop_det  = scl_s & scl_q & ~sda_q & sda_s;  // [RL2]

  // ========================================================================
  // Bus busy tracking.
  logic [31:0] idle_cnt;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bus_busy <= 1'b0;
      idle_cnt <= 32'h0000_0000;
    end else begin
      if (start_det) begin
        bus_busy <= 1'b1;  // [RL3]
      end else if (stop_det || idle_cnt > 32'(BUS_IDLE_CYCLES)) begin
        bus_busy <= 1'b0;  // [RL3]
      end
      if (scl_s && sda_s && bus_busy) begin
        idle_cnt <= idle_cnt + 32'h0000_0001;
      end else begin
        idle_cnt <= 32'h0000_0000;
      end
    end
  end

  // ========================================================================
  // Protocol engine.
  sit_pkg::sit_state_t state;
  logic [3:0]          bit_cnt;
  logic [1:0]          byte_idx;
  logic                is_read;
  logic                is_gc;
  logic                ack_first;
  logic [5:0]          ptr;
  logic [7:0]          tx_shift;
  logic                reload_req;
  logic                addr_hit;
  logic                gc_hit;
  logic                writable;
  logic [63:0]         wr_mask;

  // The shifter is read here only while SCL is held low by this end.
  assign gc_hit   = rx_shift[7:1] == `SIT_GCALL_ADDR && !rx_shift[0];
  assign addr_hit = addr_valid && rx_shift[7:1] == target_bus_address;  // [RL5]
  assign wr_mask  = `SIT_WRITABLE_MASK;
  assign writable = wr_mask[ptr] && (!nvm_read_mode || ptr == `SIT_NVM_CTRL_LOC);  // [RL17]

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state      <= sit_pkg::ST_IDLE;
      bit_cnt    <= 4'h0;
      byte_idx   <= 2'h0;
      is_read    <= 1'b0;
      is_gc      <= 1'b0;
      ack_first  <= 1'b0;
      ptr        <= 6'h00;
      tx_shift   <= 8'h00;
      scl_oe     <= 1'b0;
      sda_oe     <= 1'b0;
      acc_valid  <= 1'b0;
      acc        <= '0;
      reload_req <= 1'b0;
    end else begin
      reload_req <= 1'b0;
      if (start_det) begin
        state    <= sit_pkg::ST_RX;  // [RL14] [RL18]
        bit_cnt  <= 4'h0;
        byte_idx <= 2'h0;
        is_gc    <= 1'b0;
        scl_oe   <= 1'b0;
        sda_oe   <= 1'b0;
      end else if (stop_det) begin
        state  <= sit_pkg::ST_IDLE;  // [RL14] [RL18]
        scl_oe <= 1'b0;
        sda_oe <= 1'b0;
      end else begin
        case (state)
          sit_pkg::ST_IDLE: begin
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
          end
          sit_pkg::ST_RX: begin
            if (scl_rise) begin
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == 4'h8) begin
              scl_oe <= 1'b1;  // [RL4] [RL16]
              state  <= sit_pkg::ST_DECIDE;
            end
          end
          sit_pkg::ST_DECIDE: begin
            if (byte_idx == 2'h0) begin
              if (gc_hit) begin
                is_gc   <= 1'b1;
                is_read <= 1'b0;
                sda_oe  <= 1'b1;
                scl_oe  <= 1'b0;
                state   <= sit_pkg::ST_ACK;
              end else if (addr_hit) begin
                is_read <= rx_shift[0];
                if (rx_shift[0]) begin
                  ack_first <= 1'b1;
                  acc_valid <= 1'b1;  // [RL12]
                  acc       <= '{we: 1'b0, nvm: nvm_read_mode, addr: ptr, wdata: 8'h00};  // [RL20]
                  state     <= sit_pkg::ST_ACC;
                end else begin
                  sda_oe <= 1'b1;
                  scl_oe <= 1'b0;
                  state  <= sit_pkg::ST_ACK;
                end
              end else begin
                scl_oe <= 1'b0;  // [RL22]
                state  <= sit_pkg::ST_IDLE;
              end
            end else if (is_gc) begin
              if (byte_idx == 2'h1 && rx_shift == `SIT_CMD_RELOAD) begin
                reload_req <= 1'b1;  // [RL9]
              end
              sda_oe <= 1'b1;  // [RL23]
              scl_oe <= 1'b0;
              state  <= sit_pkg::ST_ACK;
            end else if (byte_idx == 2'h1) begin
              ptr    <= rx_shift[5:0];  // [RL11] [RL15] [RL20]
              sda_oe <= 1'b1;
              scl_oe <= 1'b0;
              state  <= sit_pkg::ST_ACK;
            end else if (writable) begin
              ack_first <= 1'b0;
              acc_valid <= 1'b1;
              acc       <= '{we: 1'b1, nvm: 1'b0, addr: ptr, wdata: rx_shift};
              state     <= sit_pkg::ST_ACC;
            end else begin
              ptr    <= ptr + 6'h01;  // [RL17]
              sda_oe <= 1'b1;
              scl_oe <= 1'b0;
              state  <= sit_pkg::ST_ACK;
            end
          end
          sit_pkg::ST_ACC: begin
            if (acc_ready) begin
              acc_valid <= 1'b0;
              ptr       <= ptr + 6'h01;  // [RL13] [RL16]
              if (!acc.we) begin
                tx_shift <= acc_rdata;
              end
              if (acc.we || ack_first) begin
                sda_oe <= 1'b1;
                scl_oe <= 1'b0;
                state  <= sit_pkg::ST_ACK;
              end else begin
                sda_oe  <= ~acc_rdata[7];  // [RL1]
                scl_oe  <= 1'b0;  // [RL12]
                bit_cnt <= 4'h0;
                state   <= sit_pkg::ST_TX;
              end
            end
          end
          sit_pkg::ST_ACK: begin
            if (scl_fall) begin
              bit_cnt   <= 4'h0;
              ack_first <= 1'b0;
              if (byte_idx != 2'h2) begin
                byte_idx <= byte_idx + 2'h1;
              end
              if (is_read) begin
                sda_oe <= ~tx_shift[7];
                state  <= sit_pkg::ST_TX;
              end else begin
                sda_oe <= 1'b0;
                state  <= sit_pkg::ST_RX;
              end
            end
          end
          sit_pkg::ST_TX: begin
            if (scl_fall) begin
              if (bit_cnt == 4'h7) begin
                sda_oe <= 1'b0;
                state  <= sit_pkg::ST_TXACK;
              end else begin
                tx_shift <= {tx_shift[6:0], 1'b0};
                sda_oe   <= ~tx_shift[6];
                bit_cnt  <= bit_cnt + 4'h1;
              end
            end
          end
          sit_pkg::ST_TXACK: begin
            if (scl_rise) begin
              if (sda_s) begin
                state <= sit_pkg::ST_IDLE;  // [RL14]
              end else begin
                state <= sit_pkg::ST_FETCH;
              end
            end
          end
          sit_pkg::ST_FETCH: begin
            if (scl_fall) begin
              scl_oe    <= 1'b1;  // [RL13]
              ack_first <= 1'b0;
              acc_valid <= 1'b1;
              acc       <= '{we: 1'b0, nvm: nvm_read_mode, addr: ptr, wdata: 8'h00};
              state     <= sit_pkg::ST_ACC;
            end
          end
          default: begin
            state <= sit_pkg::ST_IDLE;
          end
        endcase
      end
    end
  end

  // Only low levels are ever driven onto the lines.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      scl_o <= 1'b0;  // [RL1]
      sda_o <= 1'b0;  // [RL1]
    end else begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end
  end

  // ========================================================================
  // Non-volatile read mode follows writes of the access control location.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      nvm_read_mode <= 1'b0;
    end else if (acc_valid && acc_ready && acc.we && acc.addr == `SIT_NVM_CTRL_LOC) begin
      nvm_read_mode <= acc.wdata == `SIT_NVM_MODE_ON;  // [RL19] [RL21]
    end
  end

  // ========================================================================
  // Bus address reload from the stored address byte.
  logic        loading;
  logic [31:0] load_cnt;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      loading            <= 1'b0;
      load_cnt           <= 32'h0000_0000;
      addr_valid         <= 1'b0;  // [RL5]
      target_bus_address <= 7'h00;
    end else if (reload_req) begin
      loading  <= 1'b1;  // [RL6]
      load_cnt <= 32'h0000_0000;
    end else if (loading) begin
      if (load_cnt >= 32'(ADDR_LOAD_CYCLES - 1)) begin
        loading    <= 1'b0;  // [RL10]
        addr_valid <= 1'b1;
        if (stored_address_byte[`SIT_SAB_CTRL_BIT]) begin
          target_bus_address <= {stored_address_byte[`SIT_SAB_HI_MSB:`SIT_SAB_HI_LSB],
                                 pin_hi_sync[1], pin_lo_sync[1]};  // [RL7] [RL8]
        end else begin
          target_bus_address <= stored_address_byte[6:0];  // [RL7]
        end
      end else begin
        load_cnt <= load_cnt + 32'h0000_0001;
      end
    end
  end

endmodule

`default_nettype wire

// ### sit_i2c_target_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module sit_i2c_target_asserts #(
  parameter int BUS_IDLE_CYCLES = 50
) (
  input wire logic              clk,
  input wire logic              rstn,
  input wire logic              scl_i,
  input wire logic              scl_o,
  input wire logic              scl_oe,
  input wire logic              sda_i,
  input wire logic              sda_o,
  input wire logic              addr_select_upper_pin,
  input wire logic              addr_select_lower_pin,
  input wire logic [7:0]        stored_address_byte,
  input wire sit_pkg::sit_acc_t acc,
  input wire logic              acc_valid,
  input wire logic              acc_ready,
  input wire logic [6:0]        target_bus_address,
  input wire logic              addr_valid,
  input wire logic              nvm_read_mode,
  input wire logic              bus_busy
);
  int         idle_cnt;
  logic [6:0] merged;

  // Counts cycles with both bus lines high, for the idle timeout.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      idle_cnt <= 0;
    end else begin
      idle_cnt <= (scl_i && sda_i) ? idle_cnt + 1 : 0;
    end
  end

  assign merged = stored_address_byte[7] ?
    {stored_address_byte[6:2], addr_select_upper_pin, addr_select_lower_pin} :
    stored_address_byte[6:0];

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  open_drain_a: assert property (scl_o == 1'b0 && sda_o == 1'b0)
    else $error("bus line driven high");
  start_busy_a: assert property (
    $fell(sda_i) && scl_i && $past(scl_i) |-> ##[1:6] bus_busy)
    else $error("start did not mark bus busy");
  stop_idle_a: assert property (
    $rose(sda_i) && scl_i && $past(scl_i) |-> ##[1:6] !bus_busy)
    else $error("stop did not free bus");
  idle_free_a: assert property (idle_cnt > BUS_IDLE_CYCLES + 8 |-> !bus_busy)
    else $error("bus busy after long idle");
  stretch_acc_a: assert property (acc_valid |-> scl_oe)
    else $error("access without clock held low");
  stretch_low_a: assert property ($rose(scl_oe) |-> !scl_i)
    else $error("clock pulled low during high phase");
  acc_hold_a: assert property (acc_valid && !acc_ready |=> acc_valid && $stable(acc))
    else $error("request changed before accepted");
  acc_done_a: assert property (acc_valid && acc_ready |=> !acc_valid)
    else $error("request held after accepted");
  wr_mask_a: assert property (
    acc_valid && acc.we |-> acc.addr inside {[6'h14:6'h1D], 6'h1F} &&
    (!nvm_read_mode || acc.addr == 6'h1F))
    else $error("write to protected location");
  nvm_src_a: assert property (acc_valid && !acc.we |-> acc.nvm == nvm_read_mode)
    else $error("read source wrong for mode");
  addr_merge_a: assert property (
    addr_valid && ($changed(target_bus_address) || !$past(addr_valid))
    |-> target_bus_address == merged)
    else $error("loaded address wrong");
endmodule

bind sit_i2c_target sit_i2c_target_asserts #(
  .BUS_IDLE_CYCLES(BUS_IDLE_CYCLES)
) u_sit_i2c_target_asserts (
  .clk(clk), .rstn(rstn), .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe),
  .sda_i(sda_i), .sda_o(sda_o), .addr_select_upper_pin(addr_select_upper_pin),
  .addr_select_lower_pin(addr_select_lower_pin), .stored_address_byte(stored_address_byte),
  .acc(acc), .acc_valid(acc_valid), .acc_ready(acc_ready),
  .target_bus_address(target_bus_address), .addr_valid(addr_valid),
  .nvm_read_mode(nvm_read_mode), .bus_busy(bus_busy)
);
`default_nettype wire

// ### sit_params.svh
// Overview of operation
// RL1: Bus lines are only ever pulled low.
// RL2: Detect START and STOP while SCL high.
// RL3: Busy after START; idle after STOP/timeout.
// RL4: Hold SCL low while not ready.
// RL5: After power-up answer general call only.
// RL6: General call loads stored address byte.
// RL7: Control flag merges select pins into address.
// RL8: Default stored byte gives address 12/13; the code gives 12 to 15 from both select pins.
// RL9: General call plus 0x04 reloads address.
// RL10: Address copy completes within 300 us.
// RL11: First byte after address sets pointer.
// RL12: Stretch until read byte is loaded.
// RL13: Pointer increments per read, wraps after 63.
// RL14: STOP, restart or NACK ends a read.
// RL15: Write pointer byte selects next location.
// RL16: Stretch while storing, then increment pointer.
// RL17: Non-writable locations stay unchanged.
// RL18: STOP, restart or NACK ends a write.
// RL19: Controller writes 0x80 to enter NVM reads.
// RL20: NVM mode pointer selects memory location.
// RL21: Controller writes 0x00 to leave NVM reads.
// RL22: Target only; generates nothing but stretching.
// RL23: Other general call commands are ignored.
`ifndef SIT_PARAMS_SVH
`define SIT_PARAMS_SVH

// ==========================================================================
// Bus codes
`define SIT_GCALL_ADDR       7'h00
`define SIT_CMD_RELOAD       8'h04
`define SIT_NVM_CTRL_LOC     6'h1F
`define SIT_NVM_MODE_ON      8'h80
`define SIT_PTR_LAST         6'h3F
`define SIT_STORED_DEFAULT   8'h8C
// Locations 20..29 and 31 accept writes.
`define SIT_WRITABLE_MASK    64'h0000_0000_BFF0_0000

// ==========================================================================
// Field positions of the stored address byte
`define SIT_SAB_CTRL_BIT     7
`define SIT_SAB_HI_MSB       6
`define SIT_SAB_HI_LSB       2

// ==========================================================================
// Timing
`define SIT_CLK_MHZ          40
`define SIT_ADDR_LOAD_US     300
`define SIT_ADDR_LOAD_CYC    (`SIT_ADDR_LOAD_US * `SIT_CLK_MHZ)
`define SIT_BUS_IDLE_NS      50000
`define SIT_BUS_IDLE_CYC     ((`SIT_BUS_IDLE_NS * `SIT_CLK_MHZ) / 1000)

`endif

// ### sit_pkg.sv
package sit_pkg;

  // ========================================================================
  // Engine states
  typedef enum logic [7:0] {
    ST_IDLE   = 8'h01,
    ST_RX     = 8'h02,
    ST_DECIDE = 8'h04,
    ST_ACC    = 8'h08,
    ST_ACK    = 8'h10,
    ST_TX     = 8'h20,
    ST_TXACK  = 8'h40,
    ST_FETCH  = 8'h80
  } sit_state_t;

  // ========================================================================
  // Access request towards the register map and the NVM
  typedef struct packed {
    logic       we;
    logic       nvm;
    logic [5:0] addr;
    logic [7:0] wdata;
  } sit_acc_t;

endpackage

// ### tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic              clk, rstn, pin_hi, pin_lo, acc_ready, m_scl_low, m_sda_low, hang;
  logic              scl_o, scl_oe, sda_o, sda_oe, acc_valid, addr_valid, nvm_mode, busy;
  logic [7:0]        stored, acc_rdata;
  logic [7:0]        regs [64];
  logic [6:0]        tba;
  sit_pkg::sit_acc_t acc;
  int                dly, wait_cnt, fails, compares;
  wire               scl = !(m_scl_low | scl_oe);
  wire               sda = !(m_sda_low | sda_oe);

  sit_i2c_target #(.ADDR_LOAD_CYCLES(20), .BUS_IDLE_CYCLES(50)) u_sit_i2c_target (
    .clk(clk), .rstn(rstn), .scl_link(scl), .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe),
    .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .addr_select_upper_pin(pin_hi),
    .addr_select_lower_pin(pin_lo), .stored_address_byte(stored), .acc(acc),
    .acc_valid(acc_valid), .acc_ready(acc_ready), .acc_rdata(acc_rdata),
    .target_bus_address(tba), .addr_valid(addr_valid), .nvm_read_mode(nvm_mode),
    .bus_busy(busy));
  sit_ctl u_sit_ctl (.scl(scl), .sda(sda), .scl_low(m_scl_low), .sda_low(m_sda_low),
    .hang(hang));

  always #12.5 clk = !clk;

  // Register map and memory responder, answering after dly cycles.
  always @(posedge clk) begin
    #2;
    wait_cnt = acc_valid ? wait_cnt + 1 : 0;
    acc_ready = acc_valid && !acc_ready && wait_cnt > dly;
    if (acc_ready && acc.we) regs[acc.addr] = acc.wdata;
    acc_rdata = acc.nvm ? 8'h40 + {2'h0, acc.addr} : regs[acc.addr];
  end

  task automatic print_verdict();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic send(input logic [7:0] b, input logic exp);
    logic ack;
    u_sit_ctl.wbyte(b, ack);
    chk("ack", {7'h00, exp}, {7'h00, ack});
  endtask

  task automatic get(input logic last, input logic [7:0] exp);
    logic [7:0] d;
    u_sit_ctl.rbyte(last, d);
    chk("rdata", exp, d);
  endtask

  task automatic gcall(input logic [7:0] cmd, input logic [7:0] s, input logic [1:0] p);
    @(posedge clk);
    #2;
    stored = s;
    {pin_hi, pin_lo} = p;
    u_sit_ctl.start();
    send(8'h00, 1'b1);
    send(cmd, 1'b1);
    u_sit_ctl.stop();
    repeat (30) @(posedge clk);
  endtask

  task automatic setp(input logic [7:0] p);
    u_sit_ctl.start();
    send(8'h18, 1'b1);
    send(p, 1'b1);
  endtask

  task automatic rdp(input logic [7:0] p);
    setp(p);
    u_sit_ctl.start();
    send(8'h19, 1'b1);
  endtask

  task automatic test_power_up();
    chk("addr_valid", 8'h00, {7'h00, addr_valid});
    u_sit_ctl.start();
    send(8'h18, 1'b0);
    u_sit_ctl.rise();
    repeat (60) @(posedge clk);
    chk("busy", 8'h00, {7'h00, busy});
    gcall(8'h04, 8'h8C, 2'h0);
    chk("address", 8'h0C, {1'b0, tba});
    chk("addr_valid", 8'h01, {7'h00, addr_valid});
    $display("test power_up done");
  endtask

  task automatic test_select();
    logic [7:0] sb [4];
    logic [1:0] pn [4];
    logic [6:0] e;
    sb = '{8'h8C, 8'h8F, 8'h0C, 8'hB1};
    pn = '{2'h1, 2'h2, 2'h1, 2'h3};
    for (int i = 0; i < 4; i++) begin
      gcall(8'h04, sb[i], pn[i]);
      e = sb[i][7] ? {sb[i][6:2], pn[i]} : sb[i][6:0];
      chk("address", {1'b0, e}, {1'b0, tba});
    end
    gcall(8'h06, 8'h8C, 2'h0);
    chk("address", {1'b0, e}, {1'b0, tba});
    gcall(8'h04, 8'h8C, 2'h0);
    $display("test select done");
  endtask

  task automatic test_write();
    dly = 6;
    setp(8'h1D);
    send(8'h11, 1'b1);
    send(8'h22, 1'b1);
    rdp(8'h1D);
    get(1'b0, 8'h11);
    get(1'b1, 8'h1E ^ 8'hA5);
    u_sit_ctl.stop();
    dly = 0;
    $display("test write done");
  endtask

  task automatic test_read();
    rdp(8'h3E);
    chk("busy", 8'h01, {7'h00, busy});
    get(1'b0, 8'h3E ^ 8'hA5);
    get(1'b0, 8'h3F ^ 8'hA5);
    get(1'b1, 8'hA5);
    chk("sda_oe", 8'h00, {7'h00, sda_oe});
    u_sit_ctl.stop();
    repeat (8) @(posedge clk);
    chk("busy", 8'h00, {7'h00, busy});
    $display("test read done");
  endtask

  task automatic test_nvm();
    setp(8'h1F);
    send(8'h80, 1'b1);
    u_sit_ctl.stop();
    chk("nvm_mode", 8'h01, {7'h00, nvm_mode});
    rdp(8'h3F);
    get(1'b0, 8'h7F);
    get(1'b1, 8'h40);
    u_sit_ctl.stop();
    setp(8'h1F);
    send(8'h00, 1'b1);
    u_sit_ctl.stop();
    chk("nvm_mode", 8'h00, {7'h00, nvm_mode});
    $display("test nvm done");
  endtask

  always @(posedge hang) begin
    fails++;
    print_verdict();
  end

  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    {pin_hi, pin_lo} = 2'h0;
    stored = 8'h8C;
    acc_ready = 1'b0;
    acc_rdata = 8'h00;
    dly = 0;
    wait_cnt = 0;
    fails = 0;
    compares = 0;
    for (int i = 0; i < 64; i++) regs[i] = 8'(i) ^ 8'hA5;
    repeat (5) @(posedge clk);
    #2 rstn = 1'b1;
    repeat (3) @(posedge clk);
    test_power_up();
    test_select();
    test_write();
    test_read();
    test_nvm();
    print_verdict();
  end
endmodule
`default_nettype wire
